// >>> shared/spc_defs.vh
/*
 * Register offsets, field positions, reset values and sizes of the
 * scalable PWM channel block.
 * Assumes an 8-bit register port with an 8-bit address.
 */
`ifndef SPC_DEFS_VH
`define SPC_DEFS_VH

// Register port widths
`define SPC_AW            8
`define SPC_DW            8

// Per-channel bit registers, bit n belongs to channel n
`define SPC_REG_ENABLE    8'h00
`define SPC_REG_POLARITY  8'h01
`define SPC_REG_CLKSEL_LO 8'h02
`define SPC_REG_CLKSEL_HI 8'h03
`define SPC_REG_CENTER    8'h04
// Prescaler: field A in [2:0], field B in [6:4]
`define SPC_REG_PRESCALE  8'h05
`define SPC_PRE_A_LSB     0
`define SPC_PRE_B_LSB     4
// Pair join, bit k joins channels 2k and 2k+1
`define SPC_REG_CONCAT    8'h06
// Control: bit 0 stops the prescaler input in wait mode
`define SPC_REG_CTRL      8'h07
`define SPC_CTRL_WAITSTOP 0
// Scale factors for the two scaled clocks, 0 means 256
`define SPC_REG_SCALE_A   8'h08
`define SPC_REG_SCALE_B   8'h09
// Live output levels, read only
`define SPC_REG_OUTPUTS   8'h0a
// Arrays, low three address bits pick the channel
`define SPC_BASE_PERIOD   5'h02
`define SPC_BASE_DUTY     5'h03
`define SPC_BASE_CNT_LO   5'h04
`define SPC_BASE_CNT_HI   5'h05

// Reset values
`define SPC_RST_BYTE      8'h00
`define SPC_RST_PERIOD    8'hff

// Clock source codes per channel {hi,lo}
`define SPC_SRC_A         2'h0
`define SPC_SRC_B         2'h1
`define SPC_SRC_SA        2'h2
`define SPC_SRC_SB        2'h3

// Prescaler counter width, largest division is 2 to the 7th
`define SPC_PRE_W         7

`endif

// >>> hdl/spc_channel.v
/*
 * One PWM channel: double-buffered period and duty, a dedicated counter,
 * left or center alignment and duty polarity.
 * Assumes tick_in is a one-cycle enable from the clock select logic.
 */
`timescale 1ns/10ps
module spc_channel #(
   parameter W = 16
) (
   // Clock and reset
   input  wire         clk_in,
   input  wire         rst_in,
   // Control
   input  wire         tick_in,
   input  wire         en_in,
   input  wire         pol_in,
   input  wire         center_in,
   input  wire [W-1:0] period_in,
   input  wire [W-1:0] duty_in,
   // Status and output
   output wire [W-1:0] cnt_out,
   output wire         pwm_out
);

   reg [W-1:0] cnt_q;
   reg [W-1:0] per_q;
   reg [W-1:0] dty_q;
   reg         up_q;
   reg         pwm_q;
   wire        at_top;
   wire        at_end;

   assign at_top  = ({1'b0, cnt_q} + {{W{1'b0}}, 1'b1}) >= {1'b0, per_q};
   assign at_end  = (per_q == {W{1'b0}}) ||
                    (center_in ? (!up_q && cnt_q <= {{(W-1){1'b0}}, 1'b1}) : at_top);
   assign cnt_out = cnt_q;
   assign pwm_out = pwm_q;

   ////////////////////////////////////////////////////////////////////////
   // Counter and buffer reload; new values only at zero or while disabled
   always @(posedge clk_in) begin
      if (rst_in) begin
         cnt_q <= {W{1'b0}};
         per_q <= {W{1'b0}};
         dty_q <= {W{1'b0}};
         up_q  <= 1'b1;
      end else if (!en_in) begin
         cnt_q <= {W{1'b0}};
         up_q  <= 1'b1;
         per_q <= period_in;
         dty_q <= duty_in;
      end else if (tick_in) begin
         if (at_end) begin
            cnt_q <= {W{1'b0}};
            up_q  <= 1'b1;
            per_q <= period_in;
            dty_q <= duty_in;
         end else if (!center_in) begin
            cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
         end else if (up_q) begin
            cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
            if (at_top)
               up_q <= 1'b0;
         end else begin
            cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Output: duty portion carries the polarity level, rest the inverse
   always @(posedge clk_in) begin
      if (rst_in)
         pwm_q <= 1'b0;
      else if (!en_in)
         pwm_q <= 1'b0;
      else
         pwm_q <= (cnt_q < dty_q) ? pol_in : ~pol_in;
   end

endmodule

// >>> hdl/spc_top.v
/*
 * Scalable PWM block: register port, prescaler, scaled clocks, clock
 * select and two to eight channels.
 * Assumes a single 100 MHz clock, a synchronous active-high reset and a
 * register master that never issues read and write in the same cycle.
 * The wait mode indication arrives from another domain and is synchronised.
 */
`timescale 1ns/10ps
`include "spc_defs.vh"

// Summary of operation
// - Two, four, six or eight channels, in pairs
// - Each channel has its own counter
// - Per-channel enable; output runs only when enabled
// - Polarity bit sets duty level high or low
// - Period and duty reload at zero or disabled
// - Per-channel left or center alignment
// - Eight 8-bit or four joined 16-bit channels
// - Four clock sources: A, B, scaled A, B
// - Optional prescaler clock stop in wait mode
// - Left period equals clock period times period
// - Polarity clear: high for period minus duty
// - Polarity set: high for duty counts
module spc_top #(
   parameter NCH = 8
) (
   // Clock and reset
   input  wire                  clk_in,
   input  wire                  rst_in,
   // Register port
   input  wire [`SPC_AW-1:0]    addr_in,
   input  wire [`SPC_DW-1:0]    wdata_in,
   input  wire                  wr_in,
   input  wire                  rd_in,
   output wire [`SPC_DW-1:0]    rdata_out,
   // System state
   input  wire                  wait_mode_in,
   // Channel outputs
   output wire [NCH-1:0]        pwm_out
);

   localparam NPAIR = NCH / 2;

   ////////////////////////////////////////////////////////////////////////
   // Register state
   reg  [7:0]                enable_q;
   reg  [7:0]                polarity_q;
   reg  [7:0]                clksel_lo_q;
   reg  [7:0]                clksel_hi_q;
   reg  [7:0]                center_q;
   reg  [7:0]                prescale_q;
   reg  [3:0]                concat_q;
   reg                       wait_stop_q;
   reg  [7:0]                scale_a_q;
   reg  [7:0]                scale_b_q;
   reg  [7:0]                period_q [0:7];
   reg  [7:0]                duty_q   [0:7];
   reg  [`SPC_DW-1:0]        rdata_q;
   reg  [`SPC_DW-1:0]        rdata_d;

   // Clock generation state
   reg                       wait_meta_q;
   reg                       wait_sync_q;
   reg  [`SPC_PRE_W-1:0]     pre_cnt_q;
   reg  [8:0]                sa_cnt_q;
   reg  [8:0]                sb_cnt_q;
   reg                       tick_sa_q;
   reg                       tick_sb_q;

   wire [7:0]                ch_mask;
   wire                      pre_run;
   wire [`SPC_PRE_W-1:0]     mask_a;
   wire [`SPC_PRE_W-1:0]     mask_b;
   wire                      tick_a;
   wire                      tick_b;
   wire [8:0]                sa_limit;
   wire [8:0]                sb_limit;
   wire [NCH-1:0]            pwm_w;
   wire [NCH*16-1:0]         cnt_w;
   wire [2:0]                idx;

   assign ch_mask   = (8'hff >> (8 - NCH));
   assign idx       = addr_in[2:0];
   assign rdata_out = rdata_q;
   assign pwm_out   = pwm_w;

   ////////////////////////////////////////////////////////////////////////
   // Register writes; bits of absent channels are never set
   always @(posedge clk_in) begin
      if (rst_in) begin
         enable_q    <= `SPC_RST_BYTE;
         polarity_q  <= `SPC_RST_BYTE;
         clksel_lo_q <= `SPC_RST_BYTE;
         clksel_hi_q <= `SPC_RST_BYTE;
         center_q    <= `SPC_RST_BYTE;
         prescale_q  <= `SPC_RST_BYTE;
         concat_q    <= 4'h0;
         wait_stop_q <= 1'b0;
         scale_a_q   <= `SPC_RST_BYTE;
         scale_b_q   <= `SPC_RST_BYTE;
      end else if (wr_in) begin
         case (addr_in)
            `SPC_REG_ENABLE:    enable_q    <= wdata_in & ch_mask;
            `SPC_REG_POLARITY:  polarity_q  <= wdata_in & ch_mask;
            `SPC_REG_CLKSEL_LO: clksel_lo_q <= wdata_in & ch_mask;
            `SPC_REG_CLKSEL_HI: clksel_hi_q <= wdata_in & ch_mask;
            `SPC_REG_CENTER:    center_q    <= wdata_in & ch_mask;
            `SPC_REG_PRESCALE:  prescale_q  <= wdata_in & 8'h77;
            // A pair can only be joined when its odd channel exists
            `SPC_REG_CONCAT:    concat_q    <= wdata_in[3:0] &
                                               {ch_mask[7], ch_mask[5], ch_mask[3], ch_mask[1]};
            `SPC_REG_CTRL:      wait_stop_q <= wdata_in[`SPC_CTRL_WAITSTOP];
            `SPC_REG_SCALE_A:   scale_a_q   <= wdata_in;
            `SPC_REG_SCALE_B:   scale_b_q   <= wdata_in;
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Period and duty buffers, one pair of bytes per channel slot
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_buf
         always @(posedge clk_in) begin
            if (rst_in) begin
               period_q[g] <= `SPC_RST_PERIOD;
               duty_q[g]   <= `SPC_RST_BYTE;
            end else if (wr_in && idx == g && g < NCH) begin
               // Writes land in the buffer; the channel picks them up later
               if (addr_in[7:3] == `SPC_BASE_PERIOD)
                  period_q[g] <= wdata_in;
               if (addr_in[7:3] == `SPC_BASE_DUTY)
                  duty_q[g] <= wdata_in;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Read data stands one cycle after the strobe and is zero otherwise
   always @* begin
      rdata_d = 8'h00;
      case (addr_in)
         `SPC_REG_ENABLE:    rdata_d = enable_q;
         `SPC_REG_POLARITY:  rdata_d = polarity_q;
         `SPC_REG_CLKSEL_LO: rdata_d = clksel_lo_q;
         `SPC_REG_CLKSEL_HI: rdata_d = clksel_hi_q;
         `SPC_REG_CENTER:    rdata_d = center_q;
         `SPC_REG_PRESCALE:  rdata_d = prescale_q;
         `SPC_REG_CONCAT:    rdata_d = {4'h0, concat_q};
         `SPC_REG_CTRL:      rdata_d = {7'h00, wait_stop_q};
         `SPC_REG_SCALE_A:   rdata_d = scale_a_q;
         `SPC_REG_SCALE_B:   rdata_d = scale_b_q;
         `SPC_REG_OUTPUTS:   rdata_d[NCH-1:0] = pwm_w;
         default: begin
            if (idx < NCH) begin
               case (addr_in[7:3])
                  `SPC_BASE_PERIOD: rdata_d = period_q[idx];
                  `SPC_BASE_DUTY:   rdata_d = duty_q[idx];
                  `SPC_BASE_CNT_LO: rdata_d = cnt_w[idx*16 +: 8];
                  `SPC_BASE_CNT_HI: rdata_d = cnt_w[idx*16 + 8 +: 8];
                  default:          rdata_d = 8'h00;
               endcase
            end
         end
      endcase
   end

   always @(posedge clk_in) begin
      if (rst_in)
         rdata_q <= 8'h00;
      else if (rd_in)
         rdata_q <= rdata_d;
      else
         rdata_q <= 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////
   // Wait mode comes from the system controller's domain
   always @(posedge clk_in) begin
      if (rst_in) begin
         wait_meta_q <= 1'b0;
         wait_sync_q <= 1'b0;
      end else begin
         wait_meta_q <= wait_mode_in;
         wait_sync_q <= wait_meta_q;
      end
   end

   // Stopping the prescaler freezes every channel counter too, which is the
   // power saving; channels resume mid-period when wait mode ends
   assign pre_run = !(wait_stop_q && wait_sync_q);

   ////////////////////////////////////////////////////////////////////////
   // Prescaler: A and B are the bus clock divided by 2^n, n = 0..7
   always @(posedge clk_in) begin
      if (rst_in)
         pre_cnt_q <= {`SPC_PRE_W{1'b0}};
      else if (pre_run)
         pre_cnt_q <= pre_cnt_q + {{(`SPC_PRE_W-1){1'b0}}, 1'b1};
   end

   assign mask_a = ~({`SPC_PRE_W{1'b1}} << prescale_q[`SPC_PRE_A_LSB +: 3]);
   assign mask_b = ~({`SPC_PRE_W{1'b1}} << prescale_q[`SPC_PRE_B_LSB +: 3]);
   assign tick_a = pre_run && ((pre_cnt_q & mask_a) == mask_a);
   assign tick_b = pre_run && ((pre_cnt_q & mask_b) == mask_b);

   ////////////////////////////////////////////////////////////////////////
   // Scaled clocks: A or B divided by twice the scale, zero meaning 256
   assign sa_limit = {(scale_a_q == 8'h00) ? 9'h100 : {1'b0, scale_a_q}} * 9'h002 - 9'h001;
   assign sb_limit = {(scale_b_q == 8'h00) ? 9'h100 : {1'b0, scale_b_q}} * 9'h002 - 9'h001;

   always @(posedge clk_in) begin
      if (rst_in) begin
         sa_cnt_q  <= 9'h000;
         sb_cnt_q  <= 9'h000;
         tick_sa_q <= 1'b0;
         tick_sb_q <= 1'b0;
      end else begin
         tick_sa_q <= 1'b0;
         tick_sb_q <= 1'b0;
         if (tick_a) begin
            if (sa_cnt_q >= sa_limit) begin
               sa_cnt_q  <= 9'h000;
               tick_sa_q <= 1'b1;
            end else begin
               sa_cnt_q <= sa_cnt_q + 9'h001;
            end
         end
         if (tick_b) begin
            if (sb_cnt_q >= sb_limit) begin
               sb_cnt_q  <= 9'h000;
               tick_sb_q <= 1'b1;
            end else begin
               sb_cnt_q <= sb_cnt_q + 9'h001;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Channels. In a joined pair the odd channel runs 16 bits wide with the
   // even channel's bytes as the high half; the even channel is held off
   // and the pair uses the odd channel's enable, polarity, clock and mode.
   generate
      for (g = 0; g < NCH; g = g + 1) begin : g_ch
         wire        joined;
         wire [1:0]  src;
         reg         tick;
         wire [15:0] per;
         wire [15:0] dty;

         assign joined = concat_q[g / 2];
         assign src    = {clksel_hi_q[g], clksel_lo_q[g]};

         // Clock source select per channel
         always @* begin
            case (src)
               `SPC_SRC_A:  tick = tick_a;
               `SPC_SRC_B:  tick = tick_b;
               `SPC_SRC_SA: tick = tick_sa_q;
               `SPC_SRC_SB: tick = tick_sb_q;
               default:     tick = 1'b0;
            endcase
         end

         if (g % 2 == 1) begin : g_odd
            assign per = joined ? {period_q[g - 1], period_q[g]} : {8'h00, period_q[g]};
            assign dty = joined ? {duty_q[g - 1], duty_q[g]} : {8'h00, duty_q[g]};
         end else begin : g_even
            assign per = {8'h00, period_q[g]};
            assign dty = {8'h00, duty_q[g]};
         end

         spc_channel #(
            .W (16)
         ) u_ch (
            .clk_in    (clk_in),
            .rst_in    (rst_in),
            .tick_in   (tick),
            .en_in     (enable_q[g] && !(joined && (g % 2 == 0))),
            .pol_in    (polarity_q[g]),
            .center_in (center_q[g]),
            .period_in (per),
            .duty_in   (dty),
            .cnt_out   (cnt_w[g*16 +: 16]),
            .pwm_out   (pwm_w[g])
         );
      end
   endgenerate

endmodule

// >>> test/spc_asserts.sv
/* Port-level assertions for spc_top.
   Assumes the register map of spc_defs.vh and NCH of 2, 4, 6 or 8. */
`timescale 1ns/10ps
`include "spc_defs.vh"
module spc_asserts #(
   parameter NCH = 8
) (
   input wire           clk_in,
   input wire           rst_in,
   input wire [7:0]     addr_in,
   input wire [7:0]     wdata_in,
   input wire           wr_in,
   input wire           rd_in,
   input wire [7:0]     rdata_out,
   input wire           wait_mode_in,
   input wire [NCH-1:0] pwm_out
);
   reg  [7:0] en_q, en_p1, en_p2, en_p3, cat_q, cat_p1, cat_p2, cat_p3;
   reg        stop_q;
   wire [7:0] live;
   wire [3:0] cj;
   wire [7:0] join_even;
   wire [7:0] ch_mask;
   ////////////////////////////////////////
   // Mirror of control writes; history covers the output pipeline lag
   always @(posedge clk_in) begin
      if (rst_in) begin
         {en_q, en_p1, en_p2, en_p3} <= 32'h0000_0000;
         {cat_q, cat_p1, cat_p2, cat_p3} <= 32'h0000_0000;
         stop_q <= 1'b0;
      end else begin
         if (wr_in && addr_in == `SPC_REG_ENABLE) en_q <= wdata_in;
         if (wr_in && addr_in == `SPC_REG_CONCAT) cat_q <= wdata_in;
         if (wr_in && addr_in == `SPC_REG_CTRL) stop_q <= wdata_in[0];
         {en_p1, en_p2, en_p3} <= {en_q, en_p1, en_p2};
         {cat_p1, cat_p2, cat_p3} <= {cat_q, cat_p1, cat_p2};
      end
   end
   // Channels off for long enough, and even halves of joined pairs
   assign live      = en_q | en_p1 | en_p2 | en_p3;
   assign cj        = cat_q[3:0] & cat_p1[3:0] & cat_p2[3:0] & cat_p3[3:0];
   assign join_even = {1'b0, cj[3], 1'b0, cj[2], 1'b0, cj[1], 1'b0, cj[0]};
   assign ch_mask   = 8'hff >> (8 - NCH);
   ////////////////////////////////////////
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   // Sync and pipeline need several quiet cycles before the freeze shows
   sequence s_wait_held;
      (stop_q && wait_mode_in && !wr_in) [*7];
   endsequence
   a_read_idle_zero: assert property (!rd_in |=> rdata_out == 8'h00)
      else $error("read data not zero outside read slot");
   a_unmapped_read: assert property (rd_in && addr_in == 8'hff |=> rdata_out == 8'h00)
      else $error("unmapped read not zero");
   a_enable_readback: assert property (
      rd_in && addr_in == `SPC_REG_ENABLE && !$past(wr_in) |=> rdata_out == ($past(en_q) & ch_mask))
      else $error("enable readback wrong");
   a_reset_out_low: assert property ($fell(rst_in) |-> pwm_out == '0)
      else $error("outputs not low after reset");
   a_disable_write: assert property (
      wr_in && addr_in == `SPC_REG_ENABLE && wdata_in == 8'h00 |-> ##[1:3] pwm_out == '0)
      else $error("outputs still active after disable");
   a_disabled_low: assert property ((pwm_out & ~live[NCH-1:0]) == '0)
      else $error("disabled channel drives high");
   a_join_even_low: assert property ((pwm_out & join_even[NCH-1:0]) == '0)
      else $error("even output of joined pair active");
   a_wait_freeze: assert property (s_wait_held |-> $stable(pwm_out))
      else $error("outputs moved in wait mode with stop set");
endmodule
bind spc_top spc_asserts #(.NCH(NCH)) spc_asserts_i (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
   .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
   .wait_mode_in(wait_mode_in), .pwm_out(pwm_out));

// >>> test/tb_top.sv
/* Self-checking bench for spc_top with eight channels.
   Assumes the register map of spc_defs.vh and the checker bound beside it. */
`timescale 1ns/10ps
`include "spc_defs.vh"
module tb_top;
   localparam NCH = 8;
   reg           clk_in = 1'b0;
   reg           rst_in = 1'b1;
   reg  [7:0]    addr_in = 8'h00;
   reg  [7:0]    wdata_in = 8'h00;
   reg           wr_in = 1'b0;
   reg           rd_in = 1'b0;
   reg           wait_mode_in = 1'b0;
   wire [7:0]    rdata_out;
   wire [NCH-1:0] pwm_out;
   integer       miscompares = 0;
   integer       tests_run = 0;
   integer       cycles = 0;
   integer       hi, ri, c;
   reg  [7:0]    a, b;

   spc_top #(.NCH(NCH)) spc_top_i (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .wait_mode_in(wait_mode_in), .pwm_out(pwm_out));

   // 100 MHz clock
   always #5 clk_in = ~clk_in;
   // Hang guard, far beyond the roughly 1100 cycles the run needs
   always @(posedge clk_in) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         miscompares = miscompares + 1;
         stop_test;
      end
   end
   ////////////////////////////////////////
   task stop_test;
      begin
         $display("checks %0d, mismatches %0d", tests_run, miscompares);
         if (miscompares == 0 && tests_run > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask
   task chk(input string nm, input [15:0] exp, input [15:0] got);
      begin
         tests_run = tests_run + 1;
         if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
         end
      end
   endtask
   task wr(input [7:0] ad, input [7:0] d);
      begin
         @(posedge clk_in);
         addr_in  <= ad;
         wdata_in <= d;
         wr_in    <= 1'b1;
         @(posedge clk_in);
         wr_in    <= 1'b0;
      end
   endtask
   // Read data stands only in the cycle after the strobe
   task rd(input [7:0] ad, output [7:0] d);
      begin
         @(posedge clk_in);
         addr_in <= ad;
         rd_in   <= 1'b1;
         @(posedge clk_in);
         rd_in   <= 1'b0;
         #1 d = rdata_out;
      end
   endtask
   // Back-to-back counter reads covering a full period, keeping the largest
   task cmax(input [7:0] ad, output [7:0] mx);
      begin
         mx = 8'h00;
         @(posedge clk_in);
         addr_in <= ad;
         rd_in   <= 1'b1;
         repeat (9) begin
            @(posedge clk_in);
            #1 if (rdata_out > mx) mx = rdata_out;
         end
         @(posedge clk_in);
         rd_in <= 1'b0;
      end
   endtask
   // High cycles and rising edges over n cycles
   task meas(input integer ch, input integer n, output integer h, output integer r);
      reg p;
      begin
         h = 0;
         r = 0;
         @(posedge clk_in);
         #1 p = pwm_out[ch];
         repeat (n) begin
            @(posedge clk_in);
            #1 h = h + pwm_out[ch];
            r = r + (pwm_out[ch] & ~p);
            p = pwm_out[ch];
         end
      end
   endtask
   task chan(input [7:0] ch, input [7:0] per, input [7:0] dty);
      begin
         wr(8'h10 + ch, per);
         wr(8'h18 + ch, dty);
      end
   endtask
   ////////////////////////////////////////
   task t_reset;
      begin
         rd(8'h00, a); chk("enable", 8'h00, a);
         rd(8'h10, a); chk("period0", 8'hff, a);
         rd(8'h17, a); chk("period7", 8'hff, a);
         rd(8'hff, a); chk("unmapped", 8'h00, a);
         chk("outputs", 8'h00, pwm_out);
      end
   endtask
   task t_left;
      begin
         chan(0, 4, 1);
         chan(1, 5, 1);
         wr(`SPC_REG_POLARITY, 8'h02);
         wr(`SPC_REG_ENABLE, 8'h03);
         repeat (12) @(posedge clk_in);
         meas(0, 20, hi, ri); chk("left high", 15, hi);
         chk("left period", 5, ri);
         meas(1, 20, hi, ri); chk("pol high", 4, hi);
         cmax(8'h20, a); chk("cnt0 max", 3, a);
         cmax(8'h21, a); chk("cnt1 max", 4, a);
         wr(8'h19, 8'h03);
         repeat (12) @(posedge clk_in);
         meas(1, 20, hi, ri); chk("new duty", 12, hi);
         wr(`SPC_REG_ENABLE, 8'h02);
         repeat (4) @(posedge clk_in);
         meas(0, 8, hi, ri); chk("disabled", 0, hi);
      end
   endtask
   task t_center;
      begin
         wr(`SPC_REG_ENABLE, 8'h00);
         wr(`SPC_REG_CENTER, 8'h04);
         chan(2, 4, 1);
         wr(`SPC_REG_ENABLE, 8'h04);
         repeat (12) @(posedge clk_in);
         cmax(8'h22, a); chk("center max", 4, a);
         meas(2, 16, hi, ri); chk("center high", 14, hi);
      end
   endtask
   // Channels 3, 4, 5 on B, scaled A, scaled B
   task t_clock;
      begin
         wr(`SPC_REG_ENABLE, 8'h00);
         wr(`SPC_REG_CENTER, 8'h00);
         wr(`SPC_REG_PRESCALE, 8'h10);
         wr(`SPC_REG_SCALE_A, 8'h02);
         wr(`SPC_REG_SCALE_B, 8'h02);
         wr(`SPC_REG_CLKSEL_LO, 8'h28);
         wr(`SPC_REG_CLKSEL_HI, 8'h30);
         for (c = 3; c < 6; c = c + 1) chan(c, 4, 1);
         wr(`SPC_REG_ENABLE, 8'h38);
         repeat (40) @(posedge clk_in);
         for (c = 3; c < 6; c = c + 1) begin
            meas(c, 64, hi, ri); chk("source rises", 16 >> (c - 2), ri);
         end
      end
   endtask
   task t_concat;
      begin
         wr(`SPC_REG_ENABLE, 8'h00);
         wr(`SPC_REG_CLKSEL_LO, 8'h00);
         wr(`SPC_REG_CLKSEL_HI, 8'h00);
         wr(`SPC_REG_POLARITY, 8'h00);
         wr(`SPC_REG_CONCAT, 8'h01);
         chan(0, 8'h01, 8'h00);
         chan(1, 8'h00, 8'h40);
         wr(`SPC_REG_ENABLE, 8'h03);
         repeat (300) @(posedge clk_in);
         meas(1, 256, hi, ri); chk("wide high", 192, hi);
         chk("wide rises", 1, ri);
         meas(0, 16, hi, ri); chk("even off", 0, hi);
      end
   endtask
   task t_wait;
      begin
         wr(`SPC_REG_CTRL, 8'h01);
         @(posedge clk_in);
         wait_mode_in <= 1'b1;
         repeat (8) @(posedge clk_in);
         rd(8'h21, a);
         repeat (20) @(posedge clk_in);
         rd(8'h21, b); chk("frozen cnt", a, b);
         rd(`SPC_REG_OUTPUTS, b); chk("levels", pwm_out, b);
         @(posedge clk_in);
         wait_mode_in <= 1'b0;
         repeat (10) @(posedge clk_in);
         rd(8'h21, b); chk("resumed", 1, a !== b);
      end
   endtask
   ////////////////////////////////////////
   initial begin
      repeat (20) @(posedge clk_in);
      rst_in <= 1'b0;
      t_reset;
      t_left;
      t_center;
      t_clock;
      t_concat;
      t_wait;
      stop_test;
   end
endmodule
